// ===== hdl/led_tuning_defines.vh
`ifndef LED_TUNING_DEFINES_VH
`define LED_TUNING_DEFINES_VH
// word byte addresses (offsets chosen here)
`define TUNE_LO_ADDR      12'h000
`define TUNE_HI_ADDR      12'h004
`define ROW_SEL_ADDR      12'h008
`define ROW_FLAGS_ADDR    12'h00C
`define IRQ_STATUS_ADDR   12'h010
`define IRQ_ENABLE_ADDR   12'h014
`define IRQ_CLEAR_ADDR    12'h018
// field positions inside the 48-bit configuration word
`define GREEN_EDGE_LSB    24
`define BLUE_EDGE_LSB     26
`define COARSE_LSB        32
`define FIRST_DIM_LSB     35
`define ISOLATION_BIT     39
`define BOOST_LEVEL_LSB   40
`define BOOST_EN_BIT      44
// writable bit mask of the configuration word (bits 44..32 and 27..24 in this block)
`define TUNE_WMASK        48'h1FFF_0F00_0000
// reset values
`define TUNE_RESET        48'h0800_0500_0000
`define ROW_SEL_RESET     5'h00
// interrupt status bits
`define IRQ_FLAG_NEW_BIT  0
`define IRQ_FLAG_ROW_BIT  1
`endif

// ===== hdl/sync_two_ff.v
`timescale 1ns/10ps
`default_nettype none
// two flip-flop synchroniser, one per bit
module sync_two_ff #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             clock,
  input  wire             reset,
  // data
  input  wire [WIDTH-1:0] dataIn,
  output reg  [WIDTH-1:0] dataOut
);
  reg [WIDTH-1:0] stage1_r;

  // first stage feeds only the second
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1_r <= {WIDTH{1'b0}};
      dataOut  <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= dataIn;
      dataOut  <= stage1_r;
    end
  end
endmodule // sync_two_ff
`default_nettype wire

// ===== hdl/row_flag_select.v
`timescale 1ns/10ps
`default_nettype none
// picks the flag of the located row
module row_flag_select #(
  parameter ROWS = 32,
  parameter SELW = 5
) (
  // inputs
  input  wire [ROWS-1:0] rowFlags,
  input  wire [SELW-1:0] rowSel,
  // output
  output wire            rowHit
);
  assign rowHit = rowFlags[rowSel];
endmodule // row_flag_select
`default_nettype wire

// ===== hdl/led_driver_tuning_config.v
// What this block does
// [R1] Bits 25..24 set the green turn-on edge speed, 00 slowest to 11 fastest, reset 01.
// [R2] Bits 27..26 set the blue turn-on edge speed, 00 slowest to 11 fastest, reset 01.
// [R3] Bits 32, 33, 34 enable the coarse compensation range of red, green, blue; reset off.
// [R4] Bits 38..35 give the first scan line dim level, code 0 is level 1, reset 0000.
// [R5] Bit 39 enables isolation between on and off channels, reset off.
// [R6] Bits 43..40 give the isolation boost level, applied only while bit 44 is set; bit 44 resets off.
// [R7] Bits 4..0 of the row select register name the scan line 0..31 to locate; reset 0.
// [R8] A read-only vector shows per scan line whether it has an open-load warning.
// [R9] Reserved bits read zero and ignore writes.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "led_tuning_defines.vh"
module led_driver_tuning_config #(
  parameter ROWS = 32,
  parameter SELW = 5
) (
  // clock and reset
  input  wire            clock,
  input  wire            reset,
  // apb slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  input  wire [3:0]      pstrb,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // open-load detector flags from analogue side
  input  wire [ROWS-1:0] openLoadRowFlagsIn,
  // configuration outputs
  output reg  [1:0]      greenTurnOnEdgeSpeed,
  output reg  [1:0]      blueTurnOnEdgeSpeed,
  output reg  [2:0]      coarseRangeEnable,
  output reg  [3:0]      firstLineDimLevel,
  output reg             onOffChannelIsolation,
  output reg  [3:0]      isolationBoostLevel,
  output reg             isolationBoostEnable,
  output reg  [SELW-1:0] openLoadRowNumber,
  output reg             locatedRowWarning,
  // interrupt
  output reg             irq
);
  reg  [47:0]     tune_r;
  reg  [47:0]     tune_nxt;
  reg  [SELW-1:0] rowSel_r;
  reg  [1:0]      irqStatus_r;
  reg  [1:0]      irqEnable_r;
  reg  [ROWS-1:0] flagsPrev_r;
  wire [ROWS-1:0] openLoadRowFlags;
  wire            rowHit;
  wire [47:0]     tuneMask;
  wire            access;
  wire            wrEn;
  wire [1:0]      irqEvents;
  wire [1:0]      irqClear;
  reg  [31:0]     readData;
  reg             addrOk;
  reg  [31:0]     byteMask;
  integer         i;

  // pin flags are asynchronous to this clock
  sync_two_ff #(
    .WIDTH(ROWS)
  ) flagSync (
    .clock   (clock),
    .reset   (reset),
    .dataIn  (openLoadRowFlagsIn),
    .dataOut (openLoadRowFlags)
  );

  // warning of the currently located row
  row_flag_select #(
    .ROWS(ROWS),
    .SELW(SELW)
  ) rowPick (
    .rowFlags (openLoadRowFlags),
    .rowSel   (rowSel_r),
    .rowHit   (rowHit)
  );

  // apb access phase, zero wait states
  assign tuneMask = `TUNE_WMASK; // [R9]
  assign access = psel & penable;
  assign wrEn   = access & pwrite & addrOk;

  // byte lane mask from pstrb
  always @* begin
    for (i = 0; i < 32; i = i + 1) begin
      byteMask[i] = pstrb[i/8];
    end
  end

  // address decode and read mux
  always @* begin
    addrOk   = 1'b1;
    readData = 32'h0000_0000;
    case (paddr)
      `TUNE_LO_ADDR:    readData = tune_r[31:0];
      `TUNE_HI_ADDR:    readData = {16'h0000, tune_r[47:32]};
      `ROW_SEL_ADDR:    readData = {{(32-SELW){1'b0}}, rowSel_r}; // [R7] [R9]
      `ROW_FLAGS_ADDR:  readData = openLoadRowFlags; // [R8]
      `IRQ_STATUS_ADDR: readData = {30'h0000_0000, irqStatus_r};
      `IRQ_ENABLE_ADDR: readData = {30'h0000_0000, irqEnable_r};
      `IRQ_CLEAR_ADDR:  readData = 32'h0000_0000;
      default:          addrOk   = 1'b0;
    endcase
  end

  // next configuration word, writable bits only
  always @* begin
    tune_nxt = tune_r;
    if (wrEn && paddr == `TUNE_LO_ADDR) begin
      tune_nxt[31:0] = (tune_r[31:0] & ~(byteMask & tuneMask[31:0]))
                     | (pwdata & byteMask & tuneMask[31:0]); // [R1] [R2] [R9]
    end
    if (wrEn && paddr == `TUNE_HI_ADDR) begin
      tune_nxt[47:32] = (tune_r[47:32] & ~(byteMask[15:0] & tuneMask[47:32]))
                      | (pwdata[15:0] & byteMask[15:0] & tuneMask[47:32]); // [R3] [R4] [R5] [R6] [R9]
    end
  end

  // interrupt events: located row warning rises, any flag rises
  assign irqEvents[`IRQ_FLAG_NEW_BIT] = |(openLoadRowFlags & ~flagsPrev_r);
  assign irqEvents[`IRQ_FLAG_ROW_BIT] = rowHit & ~locatedRowWarning;
  assign irqClear = (wrEn && paddr == `IRQ_CLEAR_ADDR && pstrb[0]) ? pwdata[1:0] : 2'h0;

  // registers, apb answer and interrupt
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tune_r      <= `TUNE_RESET;
      rowSel_r    <= `ROW_SEL_RESET;
      irqStatus_r <= 2'h0;
      irqEnable_r <= 2'h0;
      flagsPrev_r <= {ROWS{1'b0}};
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      irq         <= 1'b0;
      locatedRowWarning <= 1'b0;
    end else begin
      tune_r <= tune_nxt;
      if (wrEn && paddr == `ROW_SEL_ADDR && pstrb[0]) begin
        rowSel_r <= pwdata[SELW-1:0]; // [R7]
      end
      if (wrEn && paddr == `IRQ_ENABLE_ADDR && pstrb[0]) begin
        irqEnable_r <= pwdata[1:0];
      end
      // set wins over clear
      irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
      flagsPrev_r <= openLoadRowFlags;
      locatedRowWarning <= rowHit; // [R8]
      irq <= |(((irqStatus_r & ~irqClear) | irqEvents) & irqEnable_r);
      // pready and read data registered: answer one cycle after setup
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addrOk;
      prdata  <= (psel & ~penable & ~pwrite) ? readData : 32'h0000_0000;
    end
  end

  // configuration fields to the analogue circuits
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      greenTurnOnEdgeSpeed  <= 2'h1;
      blueTurnOnEdgeSpeed   <= 2'h1;
      coarseRangeEnable     <= 3'h0;
      firstLineDimLevel     <= 4'h0;
      onOffChannelIsolation <= 1'b0;
      isolationBoostLevel   <= 4'h0;
      isolationBoostEnable  <= 1'b0;
      openLoadRowNumber     <= `ROW_SEL_RESET;
    end else begin
      greenTurnOnEdgeSpeed  <= tune_r[`GREEN_EDGE_LSB +: 2]; // [R1]
      blueTurnOnEdgeSpeed   <= tune_r[`BLUE_EDGE_LSB +: 2]; // [R2]
      coarseRangeEnable     <= tune_r[`COARSE_LSB +: 3]; // [R3]
      firstLineDimLevel     <= tune_r[`FIRST_DIM_LSB +: 4]; // [R4]
      onOffChannelIsolation <= tune_r[`ISOLATION_BIT]; // [R5]
      isolationBoostEnable  <= tune_r[`BOOST_EN_BIT]; // [R6]
      // level reaches the circuit only while boost is enabled
      isolationBoostLevel   <= tune_r[`BOOST_EN_BIT] ? tune_r[`BOOST_LEVEL_LSB +: 4] : 4'h0; // [R6]
      openLoadRowNumber     <= rowSel_r; // [R7]
    end
  end
endmodule // led_driver_tuning_config
`default_nettype wire

// ===== verif/led_tuning_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// port watcher for the tuning register block
module led_tuning_checker #(parameter SELW = 5) (
  // bus
  input wire logic clock, reset, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  // fields
  input wire logic [1:0] greenTurnOnEdgeSpeed, blueTurnOnEdgeSpeed,
  input wire logic [2:0] coarseRangeEnable,
  input wire logic [3:0] isolationBoostLevel,
  input wire logic onOffChannelIsolation, isolationBoostEnable,
  input wire logic [SELW-1:0] openLoadRowNumber
);
  logic [31:0] lastW_r;
  // completed writes, by register
  wire acc = psel & penable & pready;
  wire wrLo = acc & pwrite & pstrb[3] & (paddr == 12'h000);
  wire wrHi = acc & pwrite & (&pstrb[1:0]) & (paddr == 12'h004);
  wire wrRow = acc & pwrite & pstrb[0] & (paddr == 12'h008);
  // write data kept until the field outputs follow
  always_ff @(posedge clock) if (acc) lastW_r <= pwdata;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_green_write: assert property (wrLo |-> ##2 greenTurnOnEdgeSpeed == lastW_r[25:24])
    else $error("green speed wrong");
  a_blue_write: assert property (wrLo |-> ##2 blueTurnOnEdgeSpeed == lastW_r[27:26])
    else $error("blue speed wrong");
  a_coarse_write: assert property (wrHi |-> ##2 coarseRangeEnable == lastW_r[2:0])
    else $error("coarse enables wrong");
  a_iso_write: assert property (wrHi |-> ##2 onOffChannelIsolation == lastW_r[7])
    else $error("isolation wrong");
  a_boost_gate: assert property (!isolationBoostEnable |-> isolationBoostLevel == 4'h0)
    else $error("boost level while off");
  a_boost_level: assert property (wrHi && pwdata[12] |-> ##2 isolationBoostLevel == lastW_r[11:8])
    else $error("boost level wrong");
  a_row_write: assert property (wrRow |-> ##2 openLoadRowNumber == lastW_r[SELW-1:0])
    else $error("row number wrong");
  a_unmapped_err: assert property (acc && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access answered");
  // main scenarios
  cover property (wrLo);
  cover property (wrRow);
  cover property (acc && pslverr);
endmodule // led_tuning_checker
bind led_driver_tuning_config led_tuning_checker #(.SELW(SELW)) chk_u (.clock, .reset, .psel, .penable,
  .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .greenTurnOnEdgeSpeed, .blueTurnOnEdgeSpeed,
  .coarseRangeEnable, .isolationBoostLevel, .onOffChannelIsolation, .isolationBoostEnable, .openLoadRowNumber);
`default_nettype wire

// ===== verif/apb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// bus master standing in for the display controller
module apb_host_model (
  input wire logic clock, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  bit hung;
  // idle bus at time zero
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'hF};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 16);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    hung = n >= 16;
  endtask
endmodule // apb_host_model
`default_nettype wire

// ===== verif/led_driver_tuning_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the tuning register block
module led_driver_tuning_config_bench;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, irq, locatedRowWarning;
  logic onOffChannelIsolation, isolationBoostEnable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, openLoadRowFlagsIn;
  logic [3:0] pstrb, firstLineDimLevel, isolationBoostLevel;
  logic [1:0] greenTurnOnEdgeSpeed, blueTurnOnEdgeSpeed;
  logic [2:0] coarseRangeEnable;
  logic [4:0] openLoadRowNumber;
  int n_mismatch, n_checks;
  led_driver_tuning_config dut_u (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .openLoadRowFlagsIn, .greenTurnOnEdgeSpeed, .blueTurnOnEdgeSpeed,
    .coarseRangeEnable, .firstLineDimLevel, .onOffChannelIsolation, .isolationBoostLevel,
    .isolationBoostEnable, .openLoadRowNumber, .locatedRowWarning, .irq);
  apb_host_model host_u (.clock, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus access that ends the run when the slave never answers
  task automatic xf(input bit w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                    output logic e);
    host_u.xfer(w, a, d, q, e);
    if (host_u.hung) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xf(1'b1, a, d, q, e);
    repeat (3) @(negedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    xf(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic tReset;
    rd(12'h000, 32'h0500_0000);
    rd(12'h004, 32'h0000_0800);
    rd(12'h008, 32'h0000_0000);
    chk({blueTurnOnEdgeSpeed, greenTurnOnEdgeSpeed}, 4'h5);
    $display("reset test done");
  endtask
  task automatic tSpeed;
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, (32'(i) << 24) | (32'(3 - i) << 26));
      chk({blueTurnOnEdgeSpeed, greenTurnOnEdgeSpeed}, 32'((3 - i) * 4 + i));
    end
    wr(12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0F00_0000);
    $display("speed test done");
  endtask
  task automatic tHigh;
    wr(12'h004, 32'hFFFF_FFFF);
    rd(12'h004, 32'h0000_1FFF);
    chk({coarseRangeEnable, firstLineDimLevel, onOffChannelIsolation}, 32'hFF);
    chk({isolationBoostEnable, isolationBoostLevel}, 32'h1F);
    wr(12'h004, 32'h0000_0F00);
    chk({isolationBoostEnable, isolationBoostLevel}, 32'h0);
    $display("high word test done");
  endtask
  task automatic tRow;
    wr(12'h008, 32'hFFFF_FFFF);
    rd(12'h008, 32'h0000_001F);
    chk(openLoadRowNumber, 32'h0000_001F);
    @(posedge clock) openLoadRowFlagsIn <= 32'h8000_0000;
    repeat (5) @(negedge clock);
    chk(locatedRowWarning, 1'b1);
    rd(12'h00C, 32'h8000_0000);
    wr(12'h008, 32'h0);
    chk(locatedRowWarning, 1'b0);
    $display("row test done");
  endtask
  task automatic tIrq;
    wr(12'h014, 32'h0);
    wr(12'h018, 32'h3);
    @(posedge clock) openLoadRowFlagsIn <= 32'h8000_0001;
    repeat (5) @(negedge clock);
    chk(irq, 1'b0);
    wr(12'h014, 32'h1);
    chk(irq, 1'b1);
    rd(12'h010, 32'h3);
    wr(12'h018, 32'h3);
    chk(irq, 1'b0);
    $display("interrupt test done");
  endtask
  task automatic tBad;
    logic [31:0] q;
    logic e;
    xf(1'b0, 12'h01C, 32'h0, q, e);
    chk(q, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    $display("unmapped test done");
  endtask
  // clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    openLoadRowFlagsIn = 32'h0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    tReset();
    tSpeed();
    tHigh();
    tRow();
    tIrq();
    tBad();
    summarize();
  end
endmodule // led_driver_tuning_config_bench
`default_nettype wire
